// [hw/fic_top.sv]
// fast interrupt control with ahb-lite registers
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fic_top
    import fic_pkg::*;
(
    // ahb-lite
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // peripheral requests
    input wire logic [7:0] level_req,
    // cpu sequencer
    input wire logic global_irq_on_op,
    input wire logic global_irq_off_op,
    input wire logic interrupt_return_op,
    input wire logic instr_end,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] flags_in,
    input wire logic [15:0] stack_pc,
    input wire logic [7:0] stack_flags,
    // cpu results
    output logic fast_take,
    output logic norm_take,
    output logic [2:0] take_level,
    output logic pc_load,
    output logic [15:0] pc_out,
    output logic flags_load,
    output logic [7:0] flags_out,
    output logic fast_service_flag,
    output logic irq
);
    // cpu-side requests and registers
    logic [7:0] system_mode_reg_ff, nxt_mode;
    logic [7:0] level_mask_reg_ff, level_priority_reg_ff;
    logic [1:0] stat_ff, ien_ff;
    logic fis_ff;
    fic_state_type state_ff, nxt_state;
    logic [15:0] isr_start_pointer;
    logic [7:0] shadow;
    logic [7:0] req_ok;
    logic win_any;
    logic [2:0] win_lvl;
    logic gie, fen;
    logic [2:0] fsel;
    logic take_ok, take_fast, take_norm, ret_fast, ret_norm;
    // ahb address phase
    logic ph_we_ff;
    logic [7:0] ph_addr_ff;
    logic ap_valid;
    logic wr_mode, wr_mask, wr_prio, wr_ptr, wr_stat, wr_ien;
    logic [31:0] rd_mux;
    logic [1:0] ev_set;
    logic [1:0] nxt_stat;
    logic [7:0] mode_after_op;

    assign ap_valid = hsel && hready && htrans[1];
    assign wr_mode = ph_we_ff && ph_addr_ff == FIC_OFS_MODE[7:0];
    assign wr_mask = ph_we_ff && ph_addr_ff == FIC_OFS_MASK[7:0];
    assign wr_prio = ph_we_ff && ph_addr_ff == FIC_OFS_PRIO[7:0];
    assign wr_ptr = ph_we_ff && ph_addr_ff == FIC_OFS_PTR[7:0];
    assign wr_stat = ph_we_ff && ph_addr_ff == FIC_OFS_STAT[7:0];
    assign wr_ien = ph_we_ff && ph_addr_ff == FIC_OFS_IEN[7:0];

    // mode fields
    assign gie = system_mode_reg_ff[FIC_GIE_BIT];
    assign fen = system_mode_reg_ff[FIC_FEN_BIT];
    assign fsel = system_mode_reg_ff[FIC_SEL_MSB:FIC_SEL_LSB];

    // level enable by mask bit
    assign req_ok = level_req & level_mask_reg_ff;

    fic_prio u_prio (
        .req(req_ok),
        .prio(level_priority_reg_ff),
        .any(win_any),
        .lvl(win_lvl)
    );

    // take decision
    assign take_ok = instr_end && win_any && gie && !fis_ff
        && state_ff == FIC_ST_RUN;
    // only the winning level equal to fsel, with fen set, is fast
    assign take_fast = take_ok && fen && win_lvl == fsel;
    assign take_norm = take_ok && !take_fast;
    assign ret_fast = interrupt_return_op && fis_ff;
    assign ret_norm = interrupt_return_op && !fis_ff;

    fic_swap u_swap (
        .hclk(hclk),
        .hresetn(hresetn),
        .ptr_we_hi(wr_ptr),
        .ptr_we_lo(wr_ptr),
        .ptr_wdata(hwdata[15:0]),
        .swap(take_fast || ret_fast),
        .pc_in(pc_in),
        .save_flags(take_fast),
        .flags_in(flags_in),
        .ptr_ff(isr_start_pointer),
        .shadow_ff(shadow)
    );

    // mode updates: ops, normal entry clears enable, return sets it
    always_comb begin
        mode_after_op = system_mode_reg_ff;
        if (wr_mode) mode_after_op = hwdata[7:0];
        if (global_irq_on_op || interrupt_return_op)
            mode_after_op[FIC_GIE_BIT] = 1'b1;
        if (global_irq_off_op || take_norm)
            mode_after_op[FIC_GIE_BIT] = 1'b0;
        nxt_mode = mode_after_op;
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FIC_ST_RUN: begin
                if (take_fast) nxt_state = FIC_ST_FAST;
                else if (take_norm) nxt_state = FIC_ST_NORM;
            end
            FIC_ST_FAST: nxt_state = FIC_ST_RUN;
            FIC_ST_NORM: nxt_state = FIC_ST_RUN;
            default: nxt_state = FIC_ST_RUN;
        endcase
    end

    // events: bit0 fast entry, bit1 normal entry; set wins
    assign ev_set = {take_norm, take_fast};
    assign nxt_stat = (stat_ff & ~(wr_stat ? hwdata[1:0] : 2'h0)) | ev_set;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            FIC_OFS_MODE[7:0]: rd_mux = {24'h0, system_mode_reg_ff};
            FIC_OFS_MASK[7:0]: rd_mux = {24'h0, level_mask_reg_ff};
            FIC_OFS_PRIO[7:0]: rd_mux = {24'h0, level_priority_reg_ff};
            FIC_OFS_PTR[7:0]: rd_mux = {16'h0, isr_start_pointer};
            FIC_OFS_STAT[7:0]: rd_mux = {30'h0, stat_ff};
            FIC_OFS_IEN[7:0]: rd_mux = {30'h0, ien_ff};
            FIC_OFS_STATE[7:0]: rd_mux = {29'h0, win_any, fis_ff, fen};
            FIC_OFS_SHADOW[7:0]: rd_mux = {24'h0, shadow};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_we_ff <= 1'b0;
            ph_addr_ff <= 8'h00;
        end else begin
            ph_we_ff <= ap_valid && hwrite;
            ph_addr_ff <= ap_valid ? haddr[7:0] : ph_addr_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            // read word picked in address phase, stands in data phase
            hrdata <= (ap_valid && !hwrite) ? rd_mux : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_mode_reg_ff <= FIC_MODE_RST;
            level_mask_reg_ff <= FIC_MASK_RST;
            level_priority_reg_ff <= FIC_PRIO_RST;
            stat_ff <= FIC_STAT_RST;
            ien_ff <= FIC_STAT_RST;
            state_ff <= FIC_ST_RUN;
        end else begin
            system_mode_reg_ff <= nxt_mode;
            if (wr_mask) level_mask_reg_ff <= hwdata[7:0];
            if (wr_prio) level_priority_reg_ff <= hwdata[7:0];
            if (wr_ien) ien_ff <= hwdata[1:0];
            stat_ff <= nxt_stat;
            state_ff <= nxt_state;
        end
    end

    // fast status flag and cpu outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fis_ff <= 1'b0;
            fast_take <= 1'b0;
            norm_take <= 1'b0;
            take_level <= 3'h0;
            pc_load <= 1'b0;
            pc_out <= 16'h0000;
            flags_load <= 1'b0;
            flags_out <= FIC_FLAGS_RST;
            fast_service_flag <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (take_fast) fis_ff <= 1'b1;
            else if (ret_fast) fis_ff <= 1'b0;
            fast_service_flag <= take_fast || (fis_ff && !ret_fast);
            fast_take <= take_fast;
            norm_take <= take_norm;
            take_level <= win_lvl;
            pc_load <= take_fast || ret_fast || ret_norm;
            // pointer goes to counter on fast entry and on fast return
            pc_out <= (take_fast || ret_fast) ? isr_start_pointer
                : stack_pc;
            flags_load <= take_fast || interrupt_return_op;
            if (take_fast)
                flags_out <= flags_in | 8'(1 << FIC_FIS_BIT);
            else if (ret_fast)
                flags_out <= shadow;
            else
                flags_out <= stack_flags;
            irq <= |(nxt_stat & ien_ff);
        end
    end
endmodule : fic_top
`default_nettype wire

// [hw/fic_pkg.sv]
// constants and types for the fast interrupt control block
package fic_pkg;
    localparam logic [31:0] FIC_OFS_MODE = 32'h0000_0000;
    localparam logic [31:0] FIC_OFS_MASK = 32'h0000_0004;
    localparam logic [31:0] FIC_OFS_PRIO = 32'h0000_0008;
    localparam logic [31:0] FIC_OFS_PTR = 32'h0000_000c;
    localparam logic [31:0] FIC_OFS_STAT = 32'h0000_0010;
    localparam logic [31:0] FIC_OFS_IEN = 32'h0000_0014;
    localparam logic [31:0] FIC_OFS_STATE = 32'h0000_0018;
    localparam logic [31:0] FIC_OFS_SHADOW = 32'h0000_001c;
    localparam int FIC_GIE_BIT = 0;
    localparam int FIC_FEN_BIT = 1;
    localparam int FIC_SEL_LSB = 2;
    localparam int FIC_SEL_MSB = 4;
    localparam int FIC_FIS_BIT = 1;
    localparam logic [7:0] FIC_MODE_RST = 8'h00;
    localparam logic [7:0] FIC_MASK_RST = 8'h00;
    localparam logic [7:0] FIC_PRIO_RST = 8'h00;
    localparam logic [15:0] FIC_PTR_RST = 16'h0000;
    localparam logic [7:0] FIC_FLAGS_RST = 8'h00;
    localparam logic [1:0] FIC_STAT_RST = 2'h0;
    localparam int FIC_LEVELS = 8;
    typedef enum logic [1:0] {FIC_ST_RUN, FIC_ST_FAST, FIC_ST_NORM}
        fic_state_type;
endpackage : fic_pkg

// [hw/fic_prio.sv]
// priority pick among pending enabled levels
`timescale 1ns/1ps
`default_nettype none
module fic_prio
    import fic_pkg::*;
(
    // request and settings
    input wire logic [7:0] req,
    input wire logic [7:0] prio,
    // winner
    output logic any,
    output logic [2:0] lvl
);
    logic [7:0] rank [8];
    logic [7:0] best;
    // rank: lower value wins; level 4 gets top rank when prio[4]
    // levels 0..3 fixed ascending, other prio bits unused; 1eh gives 4,0,1,2,3
    genvar g;
    generate
        for (g = 0; g < FIC_LEVELS; g++) begin : gen_rank
            if (g == 4) begin : g4
                assign rank[g] = prio[4] ? 8'h00 : 8'h05;
            end else if (g < 4) begin : glo
                assign rank[g] = 8'(g + 1);
            end else begin : ghi
                assign rank[g] = 8'(g + 2);
            end
        end
    endgenerate
    always_comb begin
        best = 8'hff;
        lvl = 3'h0;
        any = 1'b0;
        for (int i = 0; i < FIC_LEVELS; i++) begin
            if (req[i] && rank[i] < best) begin
                best = rank[i];
                lvl = 3'(i);
                any = 1'b1;
            end
        end
    end
endmodule : fic_prio
`default_nettype wire

// [hw/fic_swap.sv]
// pointer and flags shadow storage with swap
`timescale 1ns/1ps
`default_nettype none
module fic_swap
    import fic_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // software load
    input wire logic ptr_we_hi,
    input wire logic ptr_we_lo,
    input wire logic [15:0] ptr_wdata,
    // swap control
    input wire logic swap,
    input wire logic [15:0] pc_in,
    input wire logic save_flags,
    input wire logic [7:0] flags_in,
    // stored values
    output logic [15:0] ptr_ff,
    output logic [7:0] shadow_ff
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_ff <= FIC_PTR_RST;
            shadow_ff <= FIC_FLAGS_RST;
        end else begin
            if (swap) begin
                ptr_ff <= pc_in;
            end else begin
                if (ptr_we_hi) ptr_ff[15:8] <= ptr_wdata[15:8];
                if (ptr_we_lo) ptr_ff[7:0] <= ptr_wdata[7:0];
            end
            if (save_flags) shadow_ff <= flags_in;
        end
    end
endmodule : fic_swap
`default_nettype wire

// [testbench/fic_monitor.sv]
// checker for the fast interrupt control outputs
`timescale 1ns/1ps
`default_nettype none
module fic_monitor (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched ports
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] level_req,
    input wire logic interrupt_return_op,
    input wire logic fast_take,
    input wire logic norm_take,
    input wire logic pc_load,
    input wire logic fast_service_flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_quiet;
        (level_req == 8'h00) [*3];
    endsequence
    sequence s_fast_ret;
        interrupt_return_op && fast_service_flag;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    a_single_take: assert property (!(fast_take && norm_take))
        else $error("both takes at once");
    a_fis_blocks: assert property (
        $past(fast_service_flag) && fast_service_flag
        |-> !fast_take && !norm_take)
        else $error("take while fast status set");
    a_fast_sets_fis: assert property (
        fast_take |-> ##[0:2] fast_service_flag)
        else $error("fast entry left status clear");
    a_fast_pc: assert property (fast_take |-> ##[0:1] pc_load)
        else $error("fast entry without counter load");
    a_fast_pulse: assert property (fast_take |=> !fast_take)
        else $error("fast take longer than one cycle");
    a_norm_pulse: assert property (norm_take |=> !norm_take)
        else $error("normal take longer than one cycle");
    a_fis_clear: assert property (
        s_fast_ret |-> ##[1:3] !fast_service_flag)
        else $error("fast status kept after return");
    a_ret_swap: assert property (s_fast_ret |-> ##[0:3] pc_load)
        else $error("fast return without counter load");
    a_quiet_take: assert property (
        s_quiet |-> !fast_take && !norm_take)
        else $error("take with no request");
endmodule : fic_monitor
bind fic_top fic_monitor u_fic_monitor (.hclk, .hresetn, .hreadyout,
    .hresp, .level_req, .interrupt_return_op, .fast_take, .norm_take,
    .pc_load, .fast_service_flag);
`default_nettype wire

// [testbench/fic_cpu_model.sv]
// cpu sequencer stand-in: counter and flags follow the block's loads
`timescale 1ns/1ps
`default_nettype none
module fic_cpu_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // loads from the block
    input wire logic pc_load,
    input wire logic [15:0] pc_out,
    input wire logic flags_load,
    input wire logic [7:0] flags_out,
    // cpu state to the block
    output logic instr_end,
    output logic [15:0] pc_in,
    output logic [7:0] flags_in,
    output logic [15:0] stack_pc,
    output logic [7:0] stack_flags
);
    logic [15:0] pc_ff;
    logic [7:0] flags_ff;
    assign instr_end = hresetn;
    assign pc_in = pc_ff;
    assign flags_in = flags_ff;
    assign stack_pc = 16'h0200;
    assign stack_flags = 8'h5a;
    // counter stands still between loads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_ff <= 16'h0100;
            flags_ff <= 8'ha4;
        end else begin
            if (pc_load) pc_ff <= pc_out;
            if (flags_load) flags_ff <= flags_out;
        end
    end
endmodule : fic_cpu_model
`default_nettype wire

// [testbench/fast_interrupt_control_tb.sv]
// testbench for the fast interrupt control block
`timescale 1ns/1ps
`default_nettype none
module fast_interrupt_control_tb
    import fic_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, on_op, off_op, ret_op;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] level_req;
    wire hreadyout, hresp, fast_take, norm_take, pc_load, flags_load;
    wire fast_service_flag, irq, instr_end;
    wire [31:0] hrdata;
    wire [2:0] take_level, ev;
    wire [15:0] pc_out, pc_in, stack_pc;
    wire [7:0] flags_out, flags_in, stack_flags;
    int errors, checks;
    assign ev = {pc_load, norm_take, fast_take};
    fic_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .level_req, .global_irq_on_op(on_op), .global_irq_off_op(off_op),
        .interrupt_return_op(ret_op), .instr_end, .pc_in, .flags_in,
        .stack_pc, .stack_flags, .fast_take, .norm_take, .take_level,
        .pc_load, .pc_out, .flags_load, .flags_out, .fast_service_flag,
        .irq);
    fic_cpu_model u_cpu (.hclk, .hresetn, .pc_load, .pc_out, .flags_load,
        .flags_out, .instr_end, .pc_in, .flags_in, .stack_pc, .stack_flags);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic pulse(input logic [2:0] k);
        @(posedge hclk);
        {ret_op, off_op, on_op} <= k;
        @(posedge hclk);
        {ret_op, off_op, on_op} <= 3'h0;
    endtask : pulse
    task automatic wait_ev(input int w);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (ev[w] !== 1'b1 && n < 30);
        chk("event", 32'(ev[w]), 32'h1);
    endtask : wait_ev
    task automatic quiet();
        repeat (10) begin
            @(negedge hclk);
            chk("no take", 32'(ev[1:0]), 32'h0);
        end
    endtask : quiet
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (3000) @(posedge hclk);
        errors++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        {hresetn, hsel, hwrite, on_op, off_op, ret_op} = 6'h00;
        {haddr, hwdata, rd} = '0;
        {htrans, hsize, level_req} = '0;
        {errors, checks} = '0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("ready", 32'(hreadyout), 32'h1);
        chk("fis", 32'(fast_service_flag), 32'h0);
        bus(1'b1, FIC_OFS_MASK, 32'h1f);
        bus(1'b1, FIC_OFS_PRIO, 32'h1e);
        bus(1'b1, FIC_OFS_PTR, 32'h1234);
        bus(1'b1, FIC_OFS_IEN, 32'h1);
        bus(1'b1, FIC_OFS_MODE, 32'h2);
        pulse(3'h1);
        bus(1'b0, FIC_OFS_MODE, 32'h0);
        chk("mode", rd, 32'h3);
        bus(1'b0, FIC_OFS_MASK, 32'h0);
        chk("mask", rd, 32'h1f);
        $display("test setup done");
        level_req <= 8'h01;
        wait_ev(0);
        chk("level", 32'(take_level), 32'h0);
        chk("entry pc", 32'(pc_out), 32'h1234);
        @(posedge hclk);
        level_req <= 8'h11;
        quiet();
        chk("fis", 32'(fast_service_flag), 32'h1);
        chk("irq", 32'(irq), 32'h1);
        pulse(3'h4);
        wait_ev(2);
        chk("ret pc", 32'(pc_out), 32'h0100);
        chk("ret flags", 32'(flags_out), 32'ha4);
        chk("ret load", 32'(flags_load), 32'h1);
        wait_ev(1);
        chk("level", 32'(take_level), 32'h4);
        chk("fis", 32'(fast_service_flag), 32'h0);
        $display("test fast entry done");
        @(posedge hclk);
        level_req <= 8'h01;
        pulse(3'h4);
        wait_ev(0);
        chk("reentry pc", 32'(pc_out), 32'h1234);
        @(posedge hclk);
        level_req <= 8'h00;
        pulse(3'h4);
        bus(1'b0, FIC_OFS_PTR, 32'h0);
        chk("ptr back", rd, 32'h1234);
        chk("fis", 32'(fast_service_flag), 32'h0);
        bus(1'b0, FIC_OFS_STAT, 32'h0);
        chk("stat", rd, 32'h3);
        bus(1'b1, FIC_OFS_STAT, 32'h3);
        repeat (2) @(negedge hclk);
        chk("irq", 32'(irq), 32'h0);
        bus(1'b0, FIC_OFS_STAT, 32'h0);
        chk("stat clear", rd, 32'h0);
        $display("test reentry done");
        pulse(3'h2);
        bus(1'b1, FIC_OFS_MODE, 32'he);
        @(posedge hclk);
        level_req <= 8'h08;
        quiet();
        pulse(3'h1);
        wait_ev(0);
        chk("level", 32'(take_level), 32'h3);
        $display("test global gate done");
        stop_test();
    end
endmodule : fast_interrupt_control_tb
`default_nettype wire
